// file: inc/aesc_regs.svh
// Purpose: register offsets, field positions, reset values of the severity/correctable block
// Assumes: byte addresses on the plain register port, one 32-bit word per register
// Notes: definitions only
`ifndef AESC_REGS_SVH
`define AESC_REGS_SVH

// register byte offsets
`define AESC_OFS_UE_SEV 12'h10C
`define AESC_OFS_CE_STAT 12'h110
`define AESC_OFS_CE_MASK 12'h114
`define AESC_OFS_IRQ_STAT 12'h130
`define AESC_OFS_IRQ_MASK 12'h134

// uncorrectable severity field positions
`define AESC_SEV_OBSOLETE 0
`define AESC_SEV_COMP_TO 14
`define AESC_SEV_COMPL_ABORT 15

// correctable status field positions
`define AESC_CE_RX_ERR 0
`define AESC_CE_BAD_TLP 6
`define AESC_CE_BAD_DLLP 7
`define AESC_CE_ROLLOVER 8
`define AESC_CE_REPLAY_TO 12
`define AESC_CE_ADVISORY 13

// implemented bits and reset values
`define AESC_SEV_WMASK 32'h001F3031
`define AESC_SEV_RESET 32'h00062030
`define AESC_UE_EVT_MASK 32'h001F3030
`define AESC_CE_BITS 32'h000031C1
`define AESC_CE_STAT_RESET 32'h00000000
`define AESC_CE_MASK_RESET 32'h00002000

// interrupt status layout
`define AESC_IRQ_FATAL 0
`define AESC_IRQ_NONFATAL 1
`define AESC_IRQ_CORR 2
`define AESC_IRQ_BITS 32'h00000007

// smallest address width that reaches every register
`define AESC_MIN_ADDR_W 9

`endif

// file: inc/aesc_pkg.sv
// Purpose: shared types of the severity/correctable block
// Assumes: nothing beyond the register header
// Notes: types only; numbers live in aesc_regs.svh
package aesc_pkg;

  // correctable events from the physical and link layers, one-cycle pulses
  typedef struct packed {
    logic advisory;
    logic replay_to;
    logic rollover;
    logic bad_dllp;
    logic bad_tlp;
    logic rx_err;
  } aesc_ce_evt_t;

  // uncorrectable report pulses towards the message generator
  typedef struct packed {
    logic fatal;
    logic nonfatal;
  } aesc_ue_rpt_t;

endpackage

// file: core/aesc_sev_route.sv
// Purpose: splits unmasked uncorrectable events into fatal and non-fatal
// Assumes: events, mask and severity share the 32-bit status layout
// Notes: purely combinational; the caller registers the results
`timescale 1ns/10ps
`include "aesc_regs.svh"

module aesc_sev_route (
  // inputs
  input wire logic [31:0] ue_evt,
  input wire logic [31:0] ue_mask,
  input wire logic [31:0] sev,
  // results
  output logic [31:0] log_vec,
  output logic fatal,
  output logic nonfatal
);

  logic [31:0] live;

  // masked events are neither logged nor reported [R12]
  // obsolete bit 0 and bits 14/15 are outside the event mask: no effect [R3] [R4] [R5]
  assign live = ue_evt & ~ue_mask & `AESC_UE_EVT_MASK;
  assign log_vec = live;
  // severity bit one reports fatal, zero non-fatal [R1]
  assign fatal = |(live & sev);
  assign nonfatal = |(live & ~sev);

endmodule // aesc_sev_route

// file: core/aesc_top.sv
// Purpose: uncorrectable severity and correctable status registers of a switch port
// Assumes: single clock mclk at 20 MHz; events are synchronous one-cycle pulses
// Notes: rst_n is the fundamental reset; hot_rst clears only non-sticky state
`timescale 1ns/10ps
`include "aesc_regs.svh"

// Function
// R1 - unmasked event: severity one fatal, else non-fatal
// R2 - severity sticky bits reset per documented pattern
// R3 - severity bit 0 writable, sticky, no effect
// R4 - severity bit 14 reads zero always
// R5 - severity bit 15 zero, no completer abort
// R6 - receiver error sets status bit 0
// R7 - bad transaction packet sets status bit 6
// R8 - bad link packet sets status bit 7
// R9 - replay rollover sets status bit 8
// R10 - replay timer expiry sets status bit 12
// R11 - advisory non-fatal sets status bit 13
// R12 - masked uncorrectable: no log, no report
// R13 - masked correctable unreported; advisory mask resets one
// R14 - sticky bits survive hot and link resets
// R15 - reserved bits zero; writing zero leaves status
module aesc_top #(
  parameter int ADDR_W = 12
) (
  // clock, reset, enable
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic hot_rst,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // uncorrectable events and their mask
  input wire logic [31:0] ue_evt,
  input wire logic [31:0] ue_mask,
  // correctable events
  input wire aesc_pkg::aesc_ce_evt_t ce_evt,
  // reports
  output aesc_pkg::aesc_ue_rpt_t ue_rpt,
  output logic [31:0] ue_log,
  output logic corr_rpt,
  output logic irq
);
  import aesc_pkg::*;

  if (ADDR_W < `AESC_MIN_ADDR_W || ADDR_W > 32) begin : g_chk
    $error("aesc_top: ADDR_W cannot reach the register map");
  end

  // event struct to status bit positions
  function automatic logic [31:0] ce_to_vec(input aesc_ce_evt_t e);
    logic [31:0] v;
    v = 32'h00000000;
    v[`AESC_CE_RX_ERR] = e.rx_err;
    v[`AESC_CE_BAD_TLP] = e.bad_tlp;
    v[`AESC_CE_BAD_DLLP] = e.bad_dllp;
    v[`AESC_CE_ROLLOVER] = e.rollover;
    v[`AESC_CE_REPLAY_TO] = e.replay_to;
    v[`AESC_CE_ADVISORY] = e.advisory;
    return v;
  endfunction

  // address match, offset cast to the port width (zero-extended above 12 bits, truncated below)
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [11:0] ofs);
    return a == ADDR_W'(ofs);
  endfunction

  logic [31:0] sev;
  logic [31:0] ce_stat;
  logic [31:0] ce_mask;
  logic [31:0] irq_stat;
  logic [31:0] irq_mask;
  logic [31:0] ce_vec;
  logic [31:0] route_log;
  logic route_fatal;
  logic route_nonfatal;
  logic corr_live;
  logic wr_sev;
  logic wr_ce_stat;
  logic wr_ce_mask;
  logic wr_irq_stat;
  logic wr_irq_mask;
  logic [31:0] next_ce_stat;
  logic [31:0] next_irq_stat;
  logic [31:0] next_rdata;

  assign wr_sev = reg_wr && hit(reg_addr, `AESC_OFS_UE_SEV);
  assign wr_ce_stat = reg_wr && hit(reg_addr, `AESC_OFS_CE_STAT);
  assign wr_ce_mask = reg_wr && hit(reg_addr, `AESC_OFS_CE_MASK);
  assign wr_irq_stat = reg_wr && hit(reg_addr, `AESC_OFS_IRQ_STAT);
  assign wr_irq_mask = reg_wr && hit(reg_addr, `AESC_OFS_IRQ_MASK);

  // correctable events: each one lands on its own status bit [R6] [R7] [R8] [R9] [R10] [R11]
  assign ce_vec = ce_to_vec(ce_evt);
  // a masked correctable event still logs but is not reported [R13]
  assign corr_live = |(ce_vec & ~ce_mask);

  aesc_sev_route u_route (
    .ue_evt(ue_evt),
    .ue_mask(ue_mask),
    .sev(sev),
    .log_vec(route_log),
    .fatal(route_fatal),
    .nonfatal(route_nonfatal)
  );

  // severity: sticky, only the fundamental reset restores it [R2] [R14]
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sev <= `AESC_SEV_RESET; // [R2] [R3]
    end else if (clk_en && wr_sev) begin
      // bit 0 stays writable but drives nothing; 14, 15, reserved stay zero [R3] [R4] [R5] [R15]
      sev <= reg_wdata & `AESC_SEV_WMASK;
    end
  end

  // correctable status: hardware set wins over a same-cycle clear
  always_comb begin
    next_ce_stat = ce_stat;
    if (wr_ce_stat) begin
      // zeros in the write data leave bits alone [R15]
      next_ce_stat = next_ce_stat & ~reg_wdata;
    end
    next_ce_stat = (next_ce_stat | ce_vec) & `AESC_CE_BITS; // [R6] [R7] [R8] [R9] [R10] [R11]
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ce_stat <= `AESC_CE_STAT_RESET;
    end else if (clk_en) begin
      // hot_rst deliberately not consulted: the bits are sticky [R14]
      ce_stat <= next_ce_stat;
    end
  end

  // correctable mask, sticky, advisory masked out of reset
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ce_mask <= `AESC_CE_MASK_RESET; // [R13]
    end else if (clk_en && wr_ce_mask) begin
      ce_mask <= reg_wdata & `AESC_CE_BITS; // [R14] [R15]
    end
  end

  // report pulses, registered one cycle after the event
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ue_rpt <= '0;
      ue_log <= 32'h00000000;
      corr_rpt <= 1'b0;
    end else if (clk_en) begin
      if (hot_rst) begin
        ue_rpt <= '0;
        ue_log <= 32'h00000000;
        corr_rpt <= 1'b0;
      end else begin
        ue_rpt.fatal <= route_fatal; // [R1]
        ue_rpt.nonfatal <= route_nonfatal; // [R1]
        ue_log <= route_log; // [R12]
        corr_rpt <= corr_live; // [R13]
      end
    end
  end

  // interrupt status: reports are sticky until written one, set wins over clear
  always_comb begin
    next_irq_stat = irq_stat;
    if (wr_irq_stat) begin
      next_irq_stat = next_irq_stat & ~reg_wdata;
    end
    next_irq_stat[`AESC_IRQ_FATAL] = next_irq_stat[`AESC_IRQ_FATAL] | route_fatal;
    next_irq_stat[`AESC_IRQ_NONFATAL] = next_irq_stat[`AESC_IRQ_NONFATAL] | route_nonfatal;
    next_irq_stat[`AESC_IRQ_CORR] = next_irq_stat[`AESC_IRQ_CORR] | corr_live;
    next_irq_stat = next_irq_stat & `AESC_IRQ_BITS;
  end

  // interrupt state is not sticky: any reset clears it
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat <= 32'h00000000;
    end else if (clk_en) begin
      irq_stat <= hot_rst ? 32'h00000000 : next_irq_stat;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq_mask <= 32'h00000000;
    end else if (clk_en) begin
      if (hot_rst) begin
        irq_mask <= 32'h00000000;
      end else if (wr_irq_mask) begin
        irq_mask <= reg_wdata & `AESC_IRQ_BITS;
      end
    end
  end

  // level output, follows the status one cycle later
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else if (clk_en) begin
      irq <= |(irq_stat & irq_mask);
    end
  end

  // read mux; unmapped and reserved read as zero [R15]
  always_comb begin
    next_rdata = 32'h00000000;
    if (hit(reg_addr, `AESC_OFS_UE_SEV)) begin
      next_rdata = sev;
    end else if (hit(reg_addr, `AESC_OFS_CE_STAT)) begin
      next_rdata = ce_stat;
    end else if (hit(reg_addr, `AESC_OFS_CE_MASK)) begin
      next_rdata = ce_mask;
    end else if (hit(reg_addr, `AESC_OFS_IRQ_STAT)) begin
      next_rdata = irq_stat;
    end else if (hit(reg_addr, `AESC_OFS_IRQ_MASK)) begin
      next_rdata = irq_mask;
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h00000000;
    end else if (clk_en) begin
      reg_rdata <= reg_rd ? next_rdata : 32'h00000000;
    end
  end

  // checks
  AST_UE_FATAL: assert property (@(posedge mclk) disable iff (!rst_n) // [R1]
    clk_en && !hot_rst && |(ue_evt & ~ue_mask & sev & `AESC_UE_EVT_MASK)
    |=> ue_rpt.fatal)
    else $error("unmasked event with severity one not reported fatal");

  AST_UE_NONFATAL: assert property (@(posedge mclk) disable iff (!rst_n) // [R1]
    clk_en && !hot_rst && !(|(ue_evt & ~ue_mask & ~sev & `AESC_UE_EVT_MASK))
    |=> !ue_rpt.nonfatal)
    else $error("non-fatal report without a severity-zero event");

  AST_UE_MASKED: assert property (@(posedge mclk) disable iff (!rst_n) // [R12]
    clk_en && ((ue_evt & ~ue_mask) == 32'h00000000)
    |=> !ue_rpt.fatal && !ue_rpt.nonfatal && ue_log == 32'h00000000)
    else $error("masked uncorrectable event was logged or reported");

  AST_SEV_FIXED: assert property (@(posedge mclk) disable iff (!rst_n) // [R4] [R5] [R15]
    sev[`AESC_SEV_COMP_TO] == 1'b0 && sev[`AESC_SEV_COMPL_ABORT] == 1'b0
    && (sev & ~`AESC_SEV_WMASK) == 32'h00000000)
    else $error("read-only or reserved severity bit became one");

  AST_SEV_STICKY: assert property (@(posedge mclk) disable iff (!rst_n) // [R14]
    clk_en && hot_rst && !wr_sev |=> sev == $past(sev))
    else $error("severity changed across a hot reset");

  AST_CE_SET: assert property (@(posedge mclk) disable iff (!rst_n) // [R6] [R7] [R8]
    clk_en && (ce_evt.rx_err || ce_evt.bad_tlp || ce_evt.bad_dllp)
    |=> (ce_stat & $past(ce_vec)) == $past(ce_vec))
    else $error("correctable event did not set its status bit");

  AST_CE_SET_HI: assert property (@(posedge mclk) disable iff (!rst_n) // [R9] [R10] [R11]
    clk_en && (ce_evt.rollover || ce_evt.replay_to || ce_evt.advisory)
    |=> (ce_stat & $past(ce_vec)) == $past(ce_vec))
    else $error("link event did not set its status bit");

  AST_CE_W0_KEEP: assert property (@(posedge mclk) disable iff (!rst_n) // [R15]
    clk_en && wr_ce_stat && reg_wdata == 32'h00000000
    |=> (ce_stat & $past(ce_stat)) == $past(ce_stat))
    else $error("writing zero cleared a correctable status bit");

  AST_CE_HOT: assert property (@(posedge mclk) disable iff (!rst_n) // [R14]
    clk_en && hot_rst && !wr_ce_stat
    |=> (ce_stat & $past(ce_stat)) == $past(ce_stat))
    else $error("hot reset cleared correctable status");

  AST_CE_MASKED: assert property (@(posedge mclk) disable iff (!rst_n) // [R13]
    clk_en && ((ce_vec & ~ce_mask) == 32'h00000000) |=> !corr_rpt)
    else $error("masked correctable event was reported");

  AST_IRQ_LEVEL: assert property (@(posedge mclk) disable iff (!rst_n)
    clk_en && !hot_rst && !wr_irq_mask
    && |({corr_live, route_nonfatal, route_fatal} & irq_mask[2:0])
    ##1 clk_en |=> irq)
    else $error("unmasked report did not raise irq");

  AST_SEV_OBSOLETE: assert property (@(posedge mclk) disable iff (!rst_n) // [R3]
    clk_en && ((ue_evt & 32'hFFFFFFFE) == 32'h00000000)
    |=> !ue_rpt.fatal && !ue_rpt.nonfatal && ue_log == 32'h00000000)
    else $error("obsolete event bit produced a report or a log entry");

  AST_SEV_BIT0_RW: assert property (@(posedge mclk) disable iff (!rst_n) // [R3]
    clk_en && wr_sev
    |=> sev[`AESC_SEV_OBSOLETE] == $past(reg_wdata[`AESC_SEV_OBSOLETE]))
    else $error("obsolete severity bit did not take the written value");

  AST_SEV_RD: assert property (@(posedge mclk) disable iff (!rst_n) // [R4] [R5] [R15]
    clk_en && reg_rd && hit(reg_addr, `AESC_OFS_UE_SEV)
    |=> (reg_rdata & ~`AESC_SEV_WMASK) == 32'h00000000)
    else $error("read-only or reserved severity bit read as one");

  AST_CE_RD: assert property (@(posedge mclk) disable iff (!rst_n) // [R15]
    clk_en && reg_rd && (hit(reg_addr, `AESC_OFS_CE_STAT) || hit(reg_addr, `AESC_OFS_CE_MASK))
    |=> (reg_rdata & ~`AESC_CE_BITS) == 32'h00000000)
    else $error("reserved correctable bit read as one");

  AST_CE_W1C: assert property (@(posedge mclk) disable iff (!rst_n) // [R6]
    clk_en && wr_ce_stat && ((ce_vec & reg_wdata) == 32'h00000000)
    |=> (ce_stat & $past(reg_wdata)) == 32'h00000000)
    else $error("writing one did not clear a correctable status bit");

  AST_CE_ONLY_W1C: assert property (@(posedge mclk) disable iff (!rst_n) // [R6] [R14]
    clk_en && !wr_ce_stat
    |=> (ce_stat & $past(ce_stat)) == $past(ce_stat))
    else $error("correctable status fell without a write");

  AST_CE_REPORT: assert property (@(posedge mclk) disable iff (!rst_n) // [R13]
    clk_en && !hot_rst && ((ce_vec & ~ce_mask) != 32'h00000000)
    |=> corr_rpt)
    else $error("unmasked correctable event was not reported");

  // register port, clock enable and interrupt level
  AST_RDATA_IDLE: assert property (@(posedge mclk) disable iff (!rst_n)
    clk_en && !reg_rd
    |=> reg_rdata == 32'h00000000)
    else $error("read data stood outside the read cycle");

  AST_IRQ_LOW: assert property (@(posedge mclk) disable iff (!rst_n)
    clk_en && ((irq_stat & irq_mask) == 32'h00000000)
    |=> !irq)
    else $error("irq high with no unmasked status bit");

  AST_FROZEN: assert property (@(posedge mclk) disable iff (!rst_n)
    !clk_en
    |=> $stable(sev) && $stable(ce_stat) && $stable(ce_mask) && $stable(irq_stat)
    && $stable(reg_rdata) && $stable(irq))
    else $error("state changed while the clock enable was low");

endmodule // aesc_top

// file: bench/aesc_tb.sv
// Purpose: register-level bench for the severity and correctable status block
// Assumes: read data stands in the cycle after the read strobe; events report one cycle later
// Notes: expected values are worked out here, not read back from the design
`timescale 1ns/10ps
`include "aesc_regs.svh"

module testbench;
  import aesc_pkg::*;
  logic mclk, rst_n, clk_en, hot_rst, reg_wr, reg_rd, corr_rpt, irq;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, ue_evt, ue_mask, ue_log, acc;
  aesc_ce_evt_t ce_evt;
  aesc_ue_rpt_t ue_rpt;
  int n_mismatch, compares;
  int pos [6] = '{0, 6, 7, 8, 12, 13};

  aesc_top #(.ADDR_W(12)) aesc_top_i (
    .mclk(mclk), .rst_n(rst_n), .clk_en(clk_en), .hot_rst(hot_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .ue_evt(ue_evt), .ue_mask(ue_mask), .ce_evt(ce_evt),
    .ue_rpt(ue_rpt), .ue_log(ue_log), .corr_rpt(corr_rpt), .irq(irq)
  );

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic end_sim;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  // read strobe is sampled at the second edge; data stands just after it
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask

  task automatic ue_pulse(input logic [31:0] v, input logic [31:0] m, input logic [1:0] rpt,
                          input logic [31:0] lg);
    @(posedge mclk);
    ue_evt <= v;
    ue_mask <= m;
    @(posedge mclk);
    ue_evt <= 32'h00000000;
    #1;
    chk({30'h0, ue_rpt}, {30'h0, rpt});
    chk(ue_log, lg);
  endtask

  task automatic ce_pulse(input int i, input logic exp_corr);
    @(posedge mclk);
    ce_evt <= aesc_ce_evt_t'(6'(1 << i));
    @(posedge mclk);
    ce_evt <= aesc_ce_evt_t'(6'h00);
    #1;
    chk({31'h0, corr_rpt}, {31'h0, exp_corr});
  endtask

  initial begin
    #(50 * 100000);
    n_mismatch++;
    end_sim();
  end

  initial begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    hot_rst = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 12'h000;
    reg_wdata = 32'h00000000;
    ue_evt = 32'h00000000;
    ue_mask = 32'h00000000;
    ce_evt = aesc_ce_evt_t'(6'h00);
    acc = 32'h00000000;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    rdchk(12'h10C, 32'h00062030);
    rdchk(12'h110, 32'h00000000);
    rdchk(12'h114, 32'h00002000);
    rdchk(12'h200, 32'h00000000);
    wr(12'h10C, 32'hFFFFFFFF);
    rdchk(12'h10C, 32'h001F3031);
    ue_pulse(32'h00000001, 32'h0, 2'b00, 32'h00000000);
    ue_pulse(32'h00000010, 32'h0, 2'b10, 32'h00000010);
    ue_pulse(32'h0020C000, 32'h0, 2'b00, 32'h00000000);
    wr(12'h10C, 32'h00020000);
    ue_pulse(32'h00001000, 32'h0, 2'b01, 32'h00001000);
    ue_pulse(32'h00120000, 32'h0, 2'b11, 32'h00120000);
    ue_pulse(32'h00120000, 32'h00020000, 2'b01, 32'h00100000);
    ue_pulse(32'h00001010, 32'h00001010, 2'b00, 32'h00000000);
    rdchk(12'h130, 32'h00000003);
    wr(12'h130, 32'h00000007);
    rdchk(12'h130, 32'h00000000);
    for (int i = 0; i < 6; i++) begin
      ce_pulse(i, i != 5);
      acc = acc | (32'h1 << pos[i]);
      rdchk(12'h110, acc);
    end
    chk({31'h0, irq}, 32'h0);
    wr(12'h110, 32'h00000000);
    rdchk(12'h110, 32'h000031C1);
    wr(12'h110, 32'h00000001);
    rdchk(12'h110, 32'h000031C0);
    wr(12'h134, 32'h00000004);
    @(posedge mclk);
    #1;
    chk({31'h0, irq}, 32'h1);
    wr(12'h130, 32'h00000004);
    @(posedge mclk);
    #1;
    chk({31'h0, irq}, 32'h0);
    ce_pulse(1, 1'b1);
    @(posedge mclk);
    #1;
    chk({31'h0, irq}, 32'h1);
    @(posedge mclk);
    hot_rst <= 1'b1;
    @(posedge mclk);
    hot_rst <= 1'b0;
    rdchk(12'h10C, 32'h00020000);
    rdchk(12'h110, 32'h000031C0);
    rdchk(12'h134, 32'h00000000);
    chk({31'h0, irq}, 32'h0);
    wr(12'h114, 32'hFFFFFFFF);
    rdchk(12'h114, 32'h000031C1);
    @(posedge mclk);
    clk_en <= 1'b0;
    wr(12'h114, 32'h00000000);
    @(posedge mclk);
    clk_en <= 1'b1;
    rdchk(12'h114, 32'h000031C1);
    // fundamental reset in mid-run returns the sticky state to its reset values
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    rdchk(12'h10C, 32'h00062030);
    rdchk(12'h110, 32'h00000000);
    rdchk(12'h114, 32'h00002000);
    end_sim();
  end
endmodule // testbench
